// *** src/rhwh_top.sv ***
// Ring health and write handshake register bank facing the controller backplane.
// Assumes the polling engine and backplane port share i_core_clk; the mode switch is a pin.
`timescale 1ns/100ps
module rhwh_top (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Mode switch pin, high selects backplane I/O presentation
    input wire logic i_memory_protect_switch_position,
    // Controller writes its output words
    input wire logic i_out_wr,
    input wire logic [4:0] i_out_addr,
    input wire logic [15:0] i_out_data,
    // Controller reads input words
    input wire logic [4:0] i_in_addr,
    output logic [15:0] o_in_data,
    // Polling engine results
    input wire logic i_poll_valid,
    input wire logic i_poll_port,
    input wire logic [6:0] i_poll_entry,
    input wire logic i_poll_ok,
    input wire logic i_ring_broken,
    input wire logic [15:0] i_pri_scan_time,
    input wire logic [15:0] i_sec_scan_time,
    // Valve registers 8 and 9 from a poll
    input wire logic i_valve_valid,
    input wire logic [3:0] i_valve_slave,
    input wire logic [15:0] i_valve_pos,
    input wire logic [15:0] i_valve_stat,
    // Valve write commands
    input wire logic i_cmd_ready,
    output logic o_cmd_valid,
    output logic [3:0] o_cmd_slave,
    output logic [15:0] o_cmd_data,
    // Indicators
    output logic o_writes_enabled,
    output logic o_io_mode
);
    import rhwh_pkg::*;

    typedef struct packed {
        rhwh_hs_type hs;
        logic [1:0] mode_sync;
        logic ring_broken;
        logic [6:0] last_entry;
        logic [15:0] pri_scan;
        logic [15:0] sec_scan;
        logic [1:0][ENTRIES-1:0] health;
        logic [SLAVES-1:0][15:0] valve_pos;
        logic [SLAVES-1:0][15:0] valve_stat;
        logic [WORDS-1:0][15:0] out_words;
        logic [15:0] in_data;
        logic writes_enabled;
    } rhwh_bank_type;

    rhwh_bank_type cur;
    rhwh_bank_type next_cur;
    logic [1:0] rst_sync;
    logic rst_n;
    logic [15:0] status_word;
    logic [SLAVES-1:0][15:0] setpoints;

    // Bit n of a word, counted 1..16 from the msb, sits at index 16-n
    function automatic int bit_index(input int n);
        return 16 - n;
    endfunction

    // Only word 0 of each port reaches the I/O map; the other words are scanner-only
    // Health word w of a port: entry 16w+1 in the msb
    function automatic logic [15:0] health_word(input logic [ENTRIES-1:0] map, input int w);
        logic [15:0] word;
        word = WORD_RESET;
        for (int k = 0; k < 16; k++) begin
            word[bit_index(k + 1)] = map[16 * w + k];
        end
        return word;
    endfunction

    // Reset release through two flops so deassertion is clean
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Status word is shared by both presentations
    always_comb begin
        status_word = WORD_RESET;
        status_word[bit_index(STAT_WAITING)] = (cur.hs == RHWH_WAIT_LOW);
        status_word[bit_index(STAT_ACK)] = (cur.hs != RHWH_WAIT_LOW);
        status_word[bit_index(STAT_RING_BROKEN)] = cur.ring_broken;
    end

    // Setpoints for slave s live in consecutive controller words
    always_comb begin
        for (int s = 0; s < SLAVES; s++) begin
            setpoints[s] = cur.out_words[int'(OUT_SETPOINT_BASE) + s];
        end
    end

    // Next state of the whole bank, including the registered read word
    always_comb begin
        logic ctl_we;
        logic we_low_seen;
        int vi;
        ctl_we = 1'b0;
        we_low_seen = 1'b0;
        vi = 0;
        next_cur = cur;
        // Mode pin crosses in through two flops before any decode reads it
        next_cur.mode_sync = {cur.mode_sync[0], i_memory_protect_switch_position};
        // Polling engine levels share the core clock, so a plain copy is enough
        next_cur.ring_broken = i_ring_broken;
        next_cur.pri_scan = i_pri_scan_time;
        next_cur.sec_scan = i_sec_scan_time;
        // Backplane output words; address width caps the exchange at 32
        if (i_out_wr) begin
            next_cur.out_words[i_out_addr] = i_out_data;
        end
        // Write-enable bit of the controller's first word, bit 16 counted from the msb
        ctl_we = cur.out_words[OUT_WRITE_ENABLE][bit_index(WE_BIT)];
        // Only a real write with the bit low counts; the cleared copy left by reset must not
        // skip the waiting step while the controller still holds its bit high
        we_low_seen = i_out_wr && i_out_addr == OUT_WRITE_ENABLE && !i_out_data[bit_index(WE_BIT)];
        // Polling results land the same way in either mode
        if (i_poll_valid) begin
            next_cur.last_entry = i_poll_entry;
            next_cur.health[i_poll_port][i_poll_entry] = i_poll_ok;
        end
        // Slaves past the fourteenth are dropped rather than aliased
        if (i_valve_valid && i_valve_slave < 4'(SLAVES)) begin
            next_cur.valve_pos[i_valve_slave] = i_valve_pos;
            next_cur.valve_stat[i_valve_slave] = i_valve_stat;
        end
        // Handshake; a dropped enable bit asks for a fresh raise
        unique case (cur.hs)
            RHWH_WAIT_LOW: begin
                if (we_low_seen) begin
                    next_cur.hs = RHWH_WAIT_HIGH;
                end
            end
            RHWH_WAIT_HIGH: begin
                if (ctl_we) begin
                    next_cur.hs = RHWH_ENABLED;
                end
            end
            RHWH_ENABLED: begin
                if (!ctl_we) begin
                    next_cur.hs = RHWH_WAIT_HIGH;
                end
            end
        endcase
        // Taken from the next state so the indicator lands with the state change
        next_cur.writes_enabled = (next_cur.hs == RHWH_ENABLED);
        // Registered read of the input word map
        // Words outside either map read as zero
        next_cur.in_data = WORD_RESET;
        if (cur.mode_sync[1]) begin
            if (i_in_addr == IO_STATUS) begin
                next_cur.in_data = status_word;
            end else if (i_in_addr == IO_LAST_ENTRY) begin
                next_cur.in_data = {9'h000, cur.last_entry};
            end else if (i_in_addr == IO_PORT1_MAP) begin
                next_cur.in_data = health_word(cur.health[0], 0);
            end else if (i_in_addr == IO_PORT2_MAP) begin
                next_cur.in_data = health_word(cur.health[1], 0);
            end else begin
                // Valve words pair up: even offsets position, odd offsets status
                vi = int'(i_in_addr) - int'(IO_VALVE_BASE);
                if (vi >= 0 && vi < 2 * SLAVES) begin
                    next_cur.in_data = vi[0] ? cur.valve_stat[vi / 2] : cur.valve_pos[vi / 2];
                end
            end
        end else begin
            // Scanner map: sixteen health words, then entry, status and scan times
            if (i_in_addr < 5'(2 * HEALTH_WORDS)) begin
                next_cur.in_data = health_word(cur.health[i_in_addr[3]], int'(i_in_addr[2:0]));
            end else if (i_in_addr == SCN_LAST_ENTRY) begin
                next_cur.in_data = {9'h000, cur.last_entry};
            end else if (i_in_addr == SCN_STATUS) begin
                next_cur.in_data = status_word;
            end else if (i_in_addr == SCN_PRI_SCAN) begin
                next_cur.in_data = cur.pri_scan;
            end else if (i_in_addr == SCN_SEC_SCAN) begin
                next_cur.in_data = cur.sec_scan;
            end
        end
    end

    // Every reset puts the handshake back at the waiting step
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
            cur.hs <= RHWH_WAIT_LOW;
        end else begin
            cur <= next_cur;
        end
    end

    // Write scheduler only runs once the handshake is complete
    // Setpoints changed while writes are off are caught by the full sweep on enable
    rhwh_write_sched #(
        .N(SLAVES)
    ) u_sched (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_enable(cur.writes_enabled),
        .i_setpoint(setpoints),
        .i_cmd_ready(i_cmd_ready),
        .o_cmd_valid(o_cmd_valid),
        .o_cmd_slave(o_cmd_slave),
        .o_cmd_data(o_cmd_data)
    );

    // Every output comes straight from a register
    assign o_in_data = cur.in_data;
    assign o_writes_enabled = cur.writes_enabled;
    assign o_io_mode = cur.mode_sync[1];
endmodule

// *** pkg/rhwh_pkg.sv ***
// Constants and types for the ring health and write handshake register bank.
// Assumes one core clock; the polling engine and the backplane port run on it.
// Notes on behaviour
// - Backplane exchanges 32 input, 32 output words
// - At most 14 slaves, registers 8/9 only
// - Polling identical in both modes; presentation differs
// - After boot, set status bit 15
// - Seeing bit 16 low: clear 15, set 16
// - Status bit 14 shows ring broken
// - Eight health words per port, port 1 first
// - Then polled entry, status, two scan times
// - Cut ring: valve healthy on reaching port
// - Bit 16 is lsb, bit 1 msb
// - Write all setpoints, then only changes
package rhwh_pkg;
    localparam int WORDS = 32;
    localparam int SLAVES = 14;
    localparam int ENTRIES = 128;
    localparam int HEALTH_WORDS = 8;
    // Input word index, scanner presentation
    localparam logic [4:0] SCN_LAST_ENTRY = 5'h10;
    localparam logic [4:0] SCN_STATUS = 5'h11;
    localparam logic [4:0] SCN_PRI_SCAN = 5'h12;
    localparam logic [4:0] SCN_SEC_SCAN = 5'h13;
    // Input word index, backplane I/O presentation
    localparam logic [4:0] IO_STATUS = 5'h00;
    localparam logic [4:0] IO_LAST_ENTRY = 5'h01;
    localparam logic [4:0] IO_PORT1_MAP = 5'h02;
    localparam logic [4:0] IO_PORT2_MAP = 5'h03;
    localparam logic [4:0] IO_VALVE_BASE = 5'h04;
    // Output word index from the controller
    localparam logic [4:0] OUT_WRITE_ENABLE = 5'h00;
    localparam logic [4:0] OUT_SETPOINT_BASE = 5'h04;
    // Status bit positions, numbered 1..16 with 16 the lsb
    localparam int STAT_RING_BROKEN = 14;
    localparam int STAT_WAITING = 15;
    localparam int STAT_ACK = 16;
    localparam int WE_BIT = 16;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    typedef enum logic [1:0] {
        RHWH_WAIT_LOW,
        RHWH_WAIT_HIGH,
        RHWH_ENABLED
    } rhwh_hs_type;
endpackage

// *** src/rhwh_write_sched.sv ***
// Valve write scheduler: full setpoint sweep on enable, then change-driven writes.
// Assumes the command sink holds ready while it can take one command.
`timescale 1ns/100ps
module rhwh_write_sched #(
    parameter int N = rhwh_pkg::SLAVES
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_enable,
    input wire logic [N-1:0][15:0] i_setpoint,
    // Command
    input wire logic i_cmd_ready,
    output logic o_cmd_valid,
    output logic [3:0] o_cmd_slave,
    output logic [15:0] o_cmd_data
);
    import rhwh_pkg::*;

    typedef struct packed {
        logic enabled;
        logic [N-1:0] pending;
        logic [N-1:0][15:0] last_sp;
        logic [3:0] ptr;
        logic cmd_valid;
        logic [3:0] cmd_slave;
        logic [15:0] cmd_data;
    } rhwh_sched_type;

    rhwh_sched_type cur;
    rhwh_sched_type next_cur;

    // Issue clears come before change detection so a change in the issue cycle wins
    always_comb begin
        next_cur = cur;
        next_cur.enabled = i_enable;
        if (cur.cmd_valid && i_cmd_ready) begin
            next_cur.cmd_valid = 1'b0;
        end
        if (!i_enable) begin
            next_cur.pending = '0;
            next_cur.cmd_valid = 1'b0;
        end else begin
            if (!next_cur.cmd_valid && cur.pending[cur.ptr]) begin
                next_cur.cmd_valid = 1'b1;
                next_cur.cmd_slave = cur.ptr;
                next_cur.cmd_data = cur.last_sp[cur.ptr];
                next_cur.pending[cur.ptr] = 1'b0;
            end
            next_cur.ptr = (cur.ptr == 4'(N - 1)) ? 4'h0 : cur.ptr + 4'h1;
            for (int s = 0; s < N; s++) begin
                if (!cur.enabled || i_setpoint[s] != cur.last_sp[s]) begin
                    next_cur.pending[s] = 1'b1;
                    next_cur.last_sp[s] = i_setpoint[s];
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_cmd_valid = cur.cmd_valid;
    assign o_cmd_slave = cur.cmd_slave;
    assign o_cmd_data = cur.cmd_data;
endmodule

// *** bench/rhwh_checker.sv ***
// Timing checks for the ring health bank: commands, handshake, mode and reads.
// Assumes it is bound to rhwh_top and sees only its ports.
`timescale 1ns/100ps
module rhwh_checker (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Controller side
    input wire logic i_memory_protect_switch_position,
    input wire logic i_out_wr,
    input wire logic [4:0] i_out_addr,
    input wire logic [15:0] i_out_data,
    input wire logic [4:0] i_in_addr,
    input wire logic [15:0] o_in_data,
    // Valve side and indicators
    input wire logic i_cmd_ready,
    input wire logic o_cmd_valid,
    input wire logic [3:0] o_cmd_slave,
    input wire logic [15:0] o_cmd_data,
    input wire logic o_writes_enabled,
    input wire logic o_io_mode
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // Controller write to the write-enable word
    wire logic we_wr = i_out_wr && i_out_addr == 5'h00;

    cmd_hold_a: assert property ((o_cmd_valid && !i_cmd_ready && o_writes_enabled) ##1 o_writes_enabled
        |-> o_cmd_valid && $stable(o_cmd_slave) && $stable(o_cmd_data)) else $error("command not held");
    no_early_cmd_a: assert property (!o_writes_enabled [*4] |-> !o_cmd_valid)
        else $error("command while writes off");
    slave_range_a: assert property (o_cmd_valid |-> o_cmd_slave < 4'he)
        else $error("command slave out of range");
    enable_on_a: assert property (we_wr && i_out_data[0] |-> ##[1:4] o_writes_enabled)
        else $error("writes not enabled");
    enable_off_a: assert property (we_wr && !i_out_data[0] |-> ##[1:4] !o_writes_enabled)
        else $error("writes not disabled");
    mode_on_a: assert property (i_memory_protect_switch_position [*6] |-> o_io_mode)
        else $error("io mode not entered");
    mode_off_a: assert property (!i_memory_protect_switch_position [*6] |-> !o_io_mode)
        else $error("io mode not left");
    unmapped_read_a: assert property (!o_io_mode && i_in_addr >= 5'h14 |=> o_in_data == 16'h0000)
        else $error("unmapped word not zero");
    // Main scenarios reached
    cover property (o_cmd_valid && i_cmd_ready);
    cover property ($rose(o_writes_enabled));
    cover property ($rose(o_io_mode));
endmodule

// *** bench/rhwh_valve_sink.sv ***
// Valve command sink standing in for the serial polling ports.
// Assumes commands arrive as valid and ready on the core clock.
`timescale 1ns/100ps
module rhwh_valve_sink (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Pacing, high stalls three cycles of four
    input wire logic i_slow,
    // Command acceptance
    output logic o_cmd_ready
);
    logic [1:0] pace;
    // Free counter; stalls make the scheduler hold its command
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pace <= 2'h0;
        end else begin
            pace <= pace + 2'h1;
        end
    end
    assign o_cmd_ready = !i_slow || pace == 2'h3;
endmodule

// *** bench/rhwh_top_tb.sv ***
// Self-checking bench for the ring health and write handshake bank.
// Assumes a 10 MHz core clock and the valve sink model beside the design.
`timescale 1ns/100ps
module rhwh_top_tb;
    import rhwh_pkg::*;
    logic clk, rstn, mps, owr, pv, pp, pok, rb, vv, rdy, cv, we, iom, slow;
    logic [4:0] oaddr, iaddr;
    logic [6:0] pe;
    logic [3:0] vs, cs;
    logic [15:0] odata, idata, pri, sec, vpos, vstat, cd, v;
    logic [15:0] sp [14];
    logic [13:0] seen;
    int mismatches, check_count, ncmd, i;
    // Read address beside expected word; scanner rows first, then I/O rows
    logic [20:0] rows [15] = '{{5'h00, 16'hf000}, {5'h08, 16'h8e00}, {5'h01, 16'h0000}, {5'h0f, 16'h0001},
        {5'h10, 16'h0002}, {5'h11, 16'h0005}, {5'h12, 16'h028e}, {5'h13, 16'h0029}, {5'h19, 16'h0000},
        {5'h00, 16'h0001}, {5'h1e, 16'h0032}, {5'h1f, 16'h0004}, {5'h02, 16'hf000}, {5'h03, 16'h8e00},
        {5'h01, 16'h0002}};

    rhwh_top i_rhwh_top (.i_core_clk(clk), .i_resetn(rstn), .i_memory_protect_switch_position(mps),
        .i_out_wr(owr), .i_out_addr(oaddr), .i_out_data(odata), .i_in_addr(iaddr), .o_in_data(idata),
        .i_poll_valid(pv), .i_poll_port(pp), .i_poll_entry(pe), .i_poll_ok(pok), .i_ring_broken(rb),
        .i_pri_scan_time(pri), .i_sec_scan_time(sec), .i_valve_valid(vv), .i_valve_slave(vs),
        .i_valve_pos(vpos), .i_valve_stat(vstat), .i_cmd_ready(rdy), .o_cmd_valid(cv), .o_cmd_slave(cs),
        .o_cmd_data(cd), .o_writes_enabled(we), .o_io_mode(iom));
    rhwh_valve_sink i_rhwh_valve_sink (.i_core_clk(clk), .i_resetn(rstn), .i_slow(slow), .o_cmd_ready(rdy));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        {owr, oaddr, odata} <= {1'b1, a, d};
        @(posedge clk);
        owr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        iaddr <= a;
        @(posedge clk);
        #1 v = idata;
    endtask
    task automatic poll(input logic p, input logic [6:0] e, input logic ok);
        @(posedge clk);
        {pv, pp, pe, pok} <= {1'b1, p, e, ok};
        @(posedge clk);
        pv <= 1'b0;
    endtask
    // Release reset and look for the waiting bit in the first reads
    task automatic wake;
        logic hit;
        hit = 1'b0;
        rstn <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            #1 if (idata === 16'h0002) hit = 1'b1;
        end
        check(hit, 1'b1);
        check(idata, 16'h0002);
    endtask

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Every accepted command must carry the setpoint last written for its slave
    always @(posedge clk) begin
        if (rstn && cv && rdy) begin
            seen[cs] <= 1'b1;
            ncmd <= ncmd + 1;
            check(cd, sp[cs]);
        end
    end
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {mps, owr, pv, pp, pok, rb, vv, slow, rstn, oaddr, odata, pe, pri, sec, vs, vpos, vstat, seen} = '0;
        {mismatches, check_count, ncmd} = '0;
        iaddr = 5'h11;
        repeat (8) @(posedge clk);
        check(we, 1'b0);
        wake();
        wr(OUT_WRITE_ENABLE, 16'h0000);
        rd(5'h11);
        check(v, 16'h0001);
        // Cut ring: entries 1-4 on port 1, 1 and 5-7 on port 2, entry 128 boundary
        @(posedge clk) {rb, pri, sec} <= {1'b1, 16'h028e, 16'h0029};
        for (i = 0; i < 5; i++) poll(1'b0, i[6:0], 1'b1);
        poll(1'b0, 7'h04, 1'b0);
        for (i = 4; i < 7; i++) poll(1'b1, i[6:0], 1'b1);
        poll(1'b1, 7'h00, 1'b1);
        poll(1'b1, 7'h7f, 1'b1);
        poll(1'b0, 7'h02, 1'b1);
        for (i = 0; i < 9; i++) begin
            rd(rows[i][20:16]);
            check(v, rows[i][15:0]);
        end
        // Setpoints, then enable with the sink stalling
        @(posedge clk) slow <= 1'b1;
        for (i = 0; i < 14; i++) begin
            sp[i] = 16'h0100 + 16'(i);
            wr(OUT_SETPOINT_BASE + i[4:0], sp[i]);
        end
        check(ncmd, 0);
        wr(OUT_WRITE_ENABLE, 16'h0001);
        for (i = 0; i < 200 && seen !== 14'h3fff; i++) @(posedge clk);
        repeat (20) @(posedge clk);
        check(we, 1'b1);
        check(seen, 14'h3fff);
        check(ncmd, 14);
        rd(5'h11);
        check(v, 16'h0005);
        @(posedge clk) slow <= 1'b0;
        sp[5] = 16'h0abc;
        wr(OUT_SETPOINT_BASE + 5'h05, sp[5]);
        repeat (30) @(posedge clk);
        check(ncmd, 15);
        // I/O presentation; slave 14 data must be ignored
        {mps, rb} <= 2'b10;
        @(posedge clk);
        {vv, vs, vpos, vstat} <= {1'b1, 4'hd, 16'h0032, 16'h0004};
        @(posedge clk);
        {vs, vpos} <= {4'he, 16'hffff};
        @(posedge clk);
        vv <= 1'b0;
        repeat (6) @(posedge clk);
        check(iom, 1'b1);
        for (i = 9; i < 15; i++) begin
            rd(rows[i][20:16]);
            check(v, rows[i][15:0]);
        end
        // Drop enable, then reset mid-run and restart the handshake
        wr(OUT_WRITE_ENABLE, 16'h0000);
        {mps, iaddr} <= {1'b0, 5'h11};
        repeat (8) @(posedge clk);
        check(we, 1'b0);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        check({cv, we}, 2'b00);
        wake();
        tally_and_finish();
    end
endmodule

bind rhwh_top rhwh_checker i_rhwh_checker (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_memory_protect_switch_position(i_memory_protect_switch_position), .i_out_wr(i_out_wr),
    .i_out_addr(i_out_addr), .i_out_data(i_out_data), .i_in_addr(i_in_addr), .o_in_data(o_in_data),
    .i_cmd_ready(i_cmd_ready), .o_cmd_valid(o_cmd_valid), .o_cmd_slave(o_cmd_slave), .o_cmd_data(o_cmd_data),
    .o_writes_enabled(o_writes_enabled), .o_io_mode(o_io_mode));
